// file: ldc_pkg.sv
// Package for the LED driver control block: register map, field layout, timing constants and carrier types
package ldc_pkg;

	// Register indices on the plain register port
	localparam logic [7:0] ADDR_BL_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BL_EN = 8'h01;
	localparam logic [7:0] ADDR_FL_CTRL = 8'h02;
	localparam logic [7:0] ADDR_FL_ARM = 8'h03;
	localparam logic [7:0] ADDR_FAULT = 8'h04;

	// Reset values
	localparam logic [7:0] RST_BL_CTRL = 8'h00;
	localparam logic [3:0] RST_BL_EN = 4'h0;
	localparam logic [4:0] RST_FL_CTRL = 5'h10;
	localparam logic RST_FL_ARM = 1'b1;

	// Field positions
	localparam int BL_CODE_LSB = 0;
	localparam int BL_CODE_W = 5;
	localparam int FADE_EN_BIT = 5;
	localparam int FADE_RATE_LSB = 6;
	localparam int FL_MODE_BIT = 0;
	localparam int FL_CODE_LSB = 1;
	localparam int FL_TO_BIT = 4;

	// Backlight code breakpoints of the current ladder and of the reduced-bias flag
	localparam logic [4:0] BL_CODE_FINE_END = 5'h17;
	localparam logic [4:0] BL_CODE_MID_END = 5'h1a;
	localparam logic [4:0] BL_CODE_LOW_BIAS_MAX = 5'h07;

	// Flash current codes
	localparam logic [3:0] SPOT_STEP_MAX = 4'h5;

	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_PERIOD_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
	localparam int SAFETY_TIMEOUT_MS = 1000;
	localparam int PUMP_FREQ_HZ = 250_000;
	localparam int PUMP_HALF_CYCLES = CLK_HZ / (2 * PUMP_FREQ_HZ);
	localparam int PUMP_HYST_MS = 4;
	localparam logic [5:0] FADE_MS_32 = 6'h20;
	localparam logic [5:0] FADE_MS_24 = 6'h18;
	localparam logic [5:0] FADE_MS_16 = 6'h10;
	localparam logic [5:0] FADE_MS_8 = 6'h08;

	// Charge pump modes
	typedef enum logic [1:0] {LDC_PUMP_1X, LDC_PUMP_1P5X, LDC_PUMP_2X} ldc_pump_mode_t;

	// Analog status inputs, asynchronous to clk_sys
	typedef struct packed {
		logic over_temp_indication;
		logic [4:0] sink_open;
		logic pump_output_ok;
		logic pump_need_up;
		logic pump_can_down;
	} ldc_analog_in_t;

	// Drive to the current sinks
	typedef struct packed {
		logic [3:0] bl_on;
		logic [4:0] bl_code;
		logic [5:0] bl_half_ma;
		logic bl_low_bias;
		logic fl_on;
		logic fl_flash_mode;
		logic [3:0] fl_step_50ma;
	} ldc_sink_t;

	// Drive to the charge pump
	typedef struct packed {
		ldc_pump_mode_t mode;
		logic phase;
		logic ilim_high;
		logic clk_run;
	} ldc_pump_t;

endpackage

// file: ldc_led_driver_control.sv
// Control logic of the backlight and flash LED driver
`timescale 1ns/100ps

// Behaviour
// - Backlight sinks run at one of 32 levels from 0.5mA to 25mA by code.
// - Ladder steps 0.5mA up to 12mA, then 1mA to 15mA, then 2mA.
// - Every backlight output is disabled after power-up until software enables it.
// - Reduced-bias flag is high for settings of 4.0mA or less.
// - With fading on, applied code walks one step at a time to target.
// - Fade step interval is 8, 16, 24 or 32 ms.
// - Flash mode current is 50mA to 400mA in 50mA steps.
// - Trigger pin high starts flash; held high, software bits govern it.
// - Spotlight mode current is 50mA to 250mA in 50mA steps.
// - Safety timer turns off only flash sink after 1 s continuous on.
// - Safety timer is on by default and software may disable it.
// - Trigger low or software clear resets safety timer and its trip.
// - Control pin low disables device and holds all registers at default.
// - All outputs off, except by over-temperature, puts device in sleep: clock and pump stopped.
// - Over-temperature turns all outputs off, registers kept.
// - An enabled sink reporting open circuit is turned off.
// - Above recovery level, low limit with flash off, high limit with flash on.
// - Pump picks 1x, 1.5x or 2x with hysteresis; 250kHz except 1x.
// - Fade bits 00=32, 01=24, 10=16, 11=8 ms per step.
// - New codes refused mid-fade; clearing fade enable jumps; rate changes live.
module ldc_led_driver_control #(
	parameter int MS_CYCLES = ldc_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Device pins
	input wire logic single_wire_ctrl_pin,
	input wire logic flash_trigger_pin,
	input wire ldc_pkg::ldc_analog_in_t analog_in,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sink and pump drive
	output ldc_pkg::ldc_sink_t sink_out,
	output ldc_pkg::ldc_pump_t pump_out,
	output logic sleep_out
);

	// Half-milliamp current for a backlight code
	function automatic logic [5:0] bl_half_ma(input logic [4:0] code);
		logic [5:0] c;
		c = {1'b0, code};
		if (code <= ldc_pkg::BL_CODE_FINE_END) begin
			bl_half_ma = c + 6'h01;
		end else if (code <= ldc_pkg::BL_CODE_MID_END) begin
			bl_half_ma = 6'h18 + 6'((c - 6'h17) << 1);
		end else begin
			bl_half_ma = 6'h1e + 6'((c - 6'h1a) << 2);
		end
	endfunction

	// Milliseconds per fade step
	function automatic logic [5:0] fade_ms(input logic [1:0] rate);
		case (rate)
			2'b00: fade_ms = ldc_pkg::FADE_MS_32;
			2'b01: fade_ms = ldc_pkg::FADE_MS_24;
			2'b10: fade_ms = ldc_pkg::FADE_MS_16;
			default: fade_ms = ldc_pkg::FADE_MS_8;
		endcase
	endfunction

	// Control pin, trigger pin and the whole analog status word
	localparam int IN_W = 2 + $bits(ldc_pkg::ldc_analog_in_t);

	// Two-flop synchronisers for every pin
	logic [IN_W-1:0] sync1_q;
	logic [IN_W-1:0] sync2_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {single_wire_ctrl_pin, flash_trigger_pin, analog_in};
			sync2_q <= sync1_q;
		end
	end

	logic single_wire_ctrl_pin_on;
	logic trig_s;
	logic ot_s;
	logic [4:0] open_s;
	logic pump_output_ok_s;
	logic need_up_s;
	logic can_down_s;
	assign {single_wire_ctrl_pin_on, trig_s, ot_s, open_s, pump_output_ok_s, need_up_s, can_down_s} = sync2_q;

	// Control pin low is a soft reset of all state but the synchronisers and read data
	logic clr;
	assign clr = !rst_n || !single_wire_ctrl_pin_on;

	// Register bits
	logic [1:0] fade_rate_q;
	logic fade_en_q;
	logic [4:0] bl_target_q;
	logic [4:0] bl_applied_q;
	logic [3:0] bl_en_q;
	logic [4:0] fl_ctrl_q;
	logic fl_arm_q;
	logic [4:0] fault_q;
	logic tripped_q;
	logic awake_q;

	logic wr_bl;
	logic wr_en;
	logic wr_fl;
	logic wr_arm;
	logic fading;
	assign wr_bl = reg_wr && reg_addr == ldc_pkg::ADDR_BL_CTRL;
	assign wr_en = reg_wr && reg_addr == ldc_pkg::ADDR_BL_EN;
	assign wr_fl = reg_wr && reg_addr == ldc_pkg::ADDR_FL_CTRL;
	assign wr_arm = reg_wr && reg_addr == ldc_pkg::ADDR_FL_ARM;
	assign fading = fade_en_q && bl_applied_q != bl_target_q;

	// Millisecond tick, halted while asleep or shut down
	logic [15:0] div_q;
	logic tick;
	assign tick = awake_q && div_q == 16'(MS_CYCLES - 1);
	always_ff @(posedge clk_sys) begin
		if (clr || !awake_q || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// Backlight control register, with fade-time refusal of new codes
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			{fade_rate_q, fade_en_q, bl_target_q} <= ldc_pkg::RST_BL_CTRL;
		end else if (wr_bl) begin
			fade_rate_q <= reg_wdata[ldc_pkg::FADE_RATE_LSB +: 2];
			fade_en_q <= reg_wdata[ldc_pkg::FADE_EN_BIT];
			if (!fading) begin
				bl_target_q <= reg_wdata[ldc_pkg::BL_CODE_LSB +: ldc_pkg::BL_CODE_W];
			end
		end
	end

	// Fade stepping of the applied code
	logic [5:0] fade_cnt_q;
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			bl_applied_q <= ldc_pkg::RST_BL_CTRL[4:0];
			fade_cnt_q <= '0;
		end else if (!fade_en_q || !fading) begin
			bl_applied_q <= bl_target_q;
			fade_cnt_q <= '0;
		end else if (tick) begin
			// Rate is read each tick, so a live change takes hold at once
			if (fade_cnt_q + 6'h01 >= fade_ms(fade_rate_q)) begin
				fade_cnt_q <= '0;
				if (bl_target_q > bl_applied_q) begin
					bl_applied_q <= bl_applied_q + 5'h01;
				end else begin
					bl_applied_q <= bl_applied_q - 5'h01;
				end
			end else begin
				fade_cnt_q <= fade_cnt_q + 6'h01;
			end
		end
	end

	// Backlight enables, off from power-up
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			bl_en_q <= ldc_pkg::RST_BL_EN;
		end else if (wr_en) begin
			bl_en_q <= reg_wdata[3:0]; // unused outputs rely on host zeros
		end
	end

	// Flash control and arm registers
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			fl_ctrl_q <= ldc_pkg::RST_FL_CTRL;
			fl_arm_q <= ldc_pkg::RST_FL_ARM;
		end else begin
			if (wr_fl) begin
				fl_ctrl_q <= reg_wdata[4:0];
			end
			if (wr_arm) begin
				fl_arm_q <= reg_wdata[0];
			end
		end
	end

	logic fl_req;
	logic fl_on;
	logic [3:0] fl_step;
	logic [3:0] bl_req;
	assign fl_req = trig_s && fl_arm_q;
	assign fl_step = {1'b0, fl_ctrl_q[ldc_pkg::FL_CODE_LSB +: 3]} + 4'h1;
	assign bl_req = bl_en_q & ~fault_q[3:0];

	// Safety timer on continuous flash on-time
	logic [9:0] safe_ms_q;
	logic fl_clear;
	assign fl_clear = !trig_s || (wr_arm && !reg_wdata[0]);
	always_ff @(posedge clk_sys) begin
		if (clr || fl_clear || !fl_on) begin
			safe_ms_q <= '0;
		end else if (tick && fl_ctrl_q[ldc_pkg::FL_TO_BIT]) begin
			safe_ms_q <= safe_ms_q + 10'h001;
		end
	end
	// Trip latch; a trip in the cycle of a clear still latches, so the sink never outlives its limit
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			tripped_q <= 1'b0;
		end else if (tick && fl_ctrl_q[ldc_pkg::FL_TO_BIT] && safe_ms_q == 10'(ldc_pkg::SAFETY_TIMEOUT_MS - 1)) begin
			tripped_q <= 1'b1;
		end else if (fl_clear) begin
			tripped_q <= 1'b0;
		end
	end

	// Open-circuit latches; set wins over the clearing enable write
	logic [4:0] open_clr;
	assign open_clr = {!fl_req, wr_en ? ~reg_wdata[3:0] : 4'h0};
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			fault_q <= '0;
		end else begin
			fault_q <= (fault_q & ~open_clr) | (open_s & {fl_on, sink_out.bl_on});
		end
	end

	// Sleep: clock wakes one cycle before any output may turn on
	logic want_awake;
	assign want_awake = (|bl_req) || (fl_req && !tripped_q && !fault_q[4]);
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			awake_q <= 1'b0;
		end else begin
			awake_q <= want_awake;
		end
	end

	// Sink drive, off in thermal shutdown
	assign fl_on = awake_q && !ot_s && fl_req && !tripped_q && !fault_q[4];
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			sink_out <= '0;
		end else begin
			sink_out.bl_on <= (awake_q && !ot_s) ? bl_req : 4'h0;
			sink_out.bl_code <= bl_applied_q;
			sink_out.bl_half_ma <= bl_half_ma(bl_applied_q);
			sink_out.bl_low_bias <= bl_target_q <= ldc_pkg::BL_CODE_LOW_BIAS_MAX;
			sink_out.fl_on <= fl_on;
			sink_out.fl_flash_mode <= fl_ctrl_q[ldc_pkg::FL_MODE_BIT];
			if (fl_ctrl_q[ldc_pkg::FL_MODE_BIT]) begin
				sink_out.fl_step_50ma <= fl_step;
			end else begin
				sink_out.fl_step_50ma <= fl_step > ldc_pkg::SPOT_STEP_MAX ? ldc_pkg::SPOT_STEP_MAX : fl_step;
			end
		end
	end

	// Pump mode selection; stepping down waits for a settled demand to avoid toggling
	ldc_pkg::ldc_pump_mode_t mode_q;
	logic [2:0] hyst_q;
	always_ff @(posedge clk_sys) begin
		if (clr || !awake_q || ot_s) begin
			mode_q <= ldc_pkg::LDC_PUMP_1X;
			hyst_q <= '0;
		end else if (need_up_s) begin
			hyst_q <= '0;
			case (mode_q)
				ldc_pkg::LDC_PUMP_1X: mode_q <= ldc_pkg::LDC_PUMP_1P5X;
				default: mode_q <= ldc_pkg::LDC_PUMP_2X;
			endcase
		end else if (!can_down_s) begin
			hyst_q <= '0;
		end else if (tick) begin
			if (hyst_q == 3'(ldc_pkg::PUMP_HYST_MS - 1)) begin
				hyst_q <= '0;
				case (mode_q)
					ldc_pkg::LDC_PUMP_2X: mode_q <= ldc_pkg::LDC_PUMP_1P5X;
					default: mode_q <= ldc_pkg::LDC_PUMP_1X;
				endcase
			end else begin
				hyst_q <= hyst_q + 3'h1;
			end
		end
	end

	// Pump switching at 250kHz, stopped in 1x
	logic [5:0] pdiv_q;
	logic phase_q;
	always_ff @(posedge clk_sys) begin
		if (clr || mode_q == ldc_pkg::LDC_PUMP_1X) begin
			pdiv_q <= '0;
			phase_q <= 1'b0;
		end else if (pdiv_q == 6'(ldc_pkg::PUMP_HALF_CYCLES - 1)) begin
			pdiv_q <= '0;
			phase_q <= !phase_q;
		end else begin
			pdiv_q <= pdiv_q + 6'h01;
		end
	end

	// Pump outputs
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			pump_out <= '{mode: ldc_pkg::LDC_PUMP_1X, phase: 1'b0, ilim_high: 1'b0, clk_run: 1'b0};
			sleep_out <= 1'b1;
		end else begin
			pump_out.mode <= mode_q;
			pump_out.phase <= phase_q && mode_q != ldc_pkg::LDC_PUMP_1X; // phase stops with the mode
			pump_out.ilim_high <= pump_output_ok_s && fl_on;
			pump_out.clk_run <= awake_q;
			sleep_out <= !awake_q;
		end
	end

	// Read data, one cycle after the read strobe; unmapped reads give zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				ldc_pkg::ADDR_BL_CTRL: reg_rdata <= {fade_rate_q, fade_en_q, bl_target_q};
				ldc_pkg::ADDR_BL_EN: reg_rdata <= {4'h0, bl_en_q};
				ldc_pkg::ADDR_FL_CTRL: reg_rdata <= {3'h0, fl_ctrl_q};
				ldc_pkg::ADDR_FL_ARM: reg_rdata <= {3'h0, ot_s, !awake_q, tripped_q, fading, fl_arm_q};
				ldc_pkg::ADDR_FAULT: reg_rdata <= {3'h0, fault_q};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule // ldc_led_driver_control

// file: ldc_led_driver_control_end.sv
// Spare design file; all logic of the block lives in the main control file
`timescale 1ns/100ps

// file: ldc_led_driver_control_sva.sv
// Assertion checker for the LED driver control block
`timescale 1ns/100ps
module ldc_led_driver_control_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Pins and register port
	input wire logic single_wire_ctrl_pin,
	input wire logic flash_trigger_pin,
	input wire ldc_pkg::ldc_analog_in_t analog_in,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Sink, pump and sleep
	input wire ldc_pkg::ldc_sink_t sink_out,
	input wire ldc_pkg::ldc_pump_t pump_out,
	input wire logic sleep_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Half-milliamp value of a code; the ladder coarsens above the fine range
	function automatic logic [5:0] half_ma(input logic [4:0] c);
		if (c <= 5'h17) return 6'(c) + 6'h01;
		if (c <= 5'h1a) return 6'h18 + 6'(c - 5'h17) * 6'h02;
		return 6'h1e + 6'(c - 5'h1a) * 6'h04;
	endfunction
	// Waits of six cycles leave room for the two-flop synchronisers
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
	property p_ladder; |sink_out.bl_on |-> sink_out.bl_half_ma == half_ma(sink_out.bl_code); endproperty
	a_ladder: assert property (p_ladder) else $error("backlight current off ladder");
	property p_flash_rng; sink_out.fl_on && sink_out.fl_flash_mode |-> sink_out.fl_step_50ma inside {[4'h1:4'h8]}; endproperty
	a_flash_rng: assert property (p_flash_rng) else $error("flash current out of range");
	property p_spot_rng; sink_out.fl_on && !sink_out.fl_flash_mode |-> sink_out.fl_step_50ma inside {[4'h1:4'h5]}; endproperty
	a_spot_rng: assert property (p_spot_rng) else $error("spotlight current out of range");
	property p_ot; analog_in.over_temp_indication [*6] |-> !sink_out.fl_on && sink_out.bl_on == 4'h0; endproperty
	a_ot: assert property (p_ot) else $error("output on while too hot");
	property p_shut; !single_wire_ctrl_pin [*6] |-> sink_out == '0 && sleep_out; endproperty
	a_shut: assert property (p_shut) else $error("active while shut down");
	property p_sleep; sleep_out |-> sink_out.bl_on == 4'h0 && !sink_out.fl_on; endproperty
	a_sleep: assert property (p_sleep) else $error("output on while asleep");
	property p_open; analog_in.sink_open[0] [*6] |-> !sink_out.bl_on[0]; endproperty
	a_open: assert property (p_open) else $error("open sink left on");
	property p_trig; !flash_trigger_pin [*6] |-> !sink_out.fl_on; endproperty
	a_trig: assert property (p_trig) else $error("flash on with trigger low");
	property p_pump; pump_out.mode == ldc_pkg::LDC_PUMP_1X && $past(pump_out.mode) == ldc_pkg::LDC_PUMP_1X
		|-> $stable(pump_out.phase); endproperty
	a_pump: assert property (p_pump) else $error("pump switching in 1x");
	property p_ilim; !sink_out.fl_on [*3] |-> !pump_out.ilim_high; endproperty
	a_ilim: assert property (p_ilim) else $error("high limit with flash off");
	// Main scenarios
	c_flash: cover property (sink_out.fl_on && sink_out.fl_flash_mode);
	c_fade: cover property (|sink_out.bl_on && $changed(sink_out.bl_code));
	c_top: cover property (|sink_out.bl_on && sink_out.bl_code == 5'h1f);
endmodule // ldc_led_driver_control_chk

bind ldc_led_driver_control ldc_led_driver_control_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.single_wire_ctrl_pin(single_wire_ctrl_pin), .flash_trigger_pin(flash_trigger_pin), .analog_in(analog_in),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sink_out(sink_out), .pump_out(pump_out), .sleep_out(sleep_out));

// file: ldc_host_model.sv
// Host controller model driving the register port
`timescale 1ns/100ps
module ldc_host_model #(
	parameter logic [3:0] LED_MASK = 4'h7
) (
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One write cycle; released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= (a == ldc_pkg::ADDR_BL_EN) ? (d & {4'h0, LED_MASK}) : d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// One read cycle
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
	endtask
endmodule // ldc_host_model

// file: tb.sv
// Self-checking testbench for the LED driver control block
`timescale 1ns/100ps
module tb;
	localparam int MS = 20;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic ctrl = 1'b1;
	logic trig = 1'b0;
	ldc_pkg::ldc_analog_in_t ain = 9'h004;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd;
	logic rd_d = 1'b0;
	ldc_pkg::ldc_sink_t so;
	ldc_pkg::ldc_pump_t po;
	logic sleep_out;
	logic [7:0] exp_q[$];
	int err_count = 0;
	int tests_run = 0;
	int seed = 80885;
	int n, e;
	logic [3:0] en;
	logic [4:0] c;
	// Clock
	always #25 clk_sys = ~clk_sys;
	ldc_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	ldc_led_driver_control #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .single_wire_ctrl_pin(ctrl),
		.flash_trigger_pin(trig), .analog_in(ain), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sink_out(so), .pump_out(po), .sleep_out(sleep_out));
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
		tests_run++;
		if (g !== ex) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, ex, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		exp_q.push_back(ex);
		host.rd(a);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Read data stand one cycle only, so the oldest note is compared mid-cycle
	always @(posedge clk_sys) rd_d <= reg_rd;
	always @(negedge clk_sys) if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		cyc(5);
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h10);
		rd(8'h03, 8'h09);
		rd(8'h07, 8'h00);
		done("reset");
		en = 4'($random(seed)) | 4'h1;
		host.wr(8'h01, {4'h0, en});
		for (int i = 0; i < 32; i++) begin
			host.wr(8'h00, 8'(i));
			cyc(3);
			e = (i <= 23) ? i + 1 : (i <= 26) ? 24 + 2 * (i - 23) : 30 + 4 * (i - 26);
			chk("bl_on", {4'h0, en & 4'h7}, so.bl_on);
			chk("bl_code", 8'(i), so.bl_code);
			chk("bl_half_ma", 8'(e), so.bl_half_ma);
			chk("bl_low_bias", i <= 7, so.bl_low_bias);
		end
		done("ladder");
		host.wr(8'h00, 8'h04);
		host.wr(8'h00, 8'he8);
		n = 0;
		c = 5'h04;
		for (int t = 0; t < 1000 && so.bl_code !== 5'h08; t++) begin
			cyc(1);
			e = t;
			if (so.bl_code !== c) begin
				chk("fade_step", c + 5'h01, so.bl_code);
				c = so.bl_code;
				n++;
			end
		end
		chk("fade_steps", 8'h04, 8'(n));
		chk("fade_time", 1, e >= 3 * 8 * MS && e <= 4 * 8 * MS + 40);
		host.wr(8'h00, 8'h20);
		cyc(100);
		host.wr(8'h00, 8'h3f);
		rd(8'h00, 8'h20);
		host.wr(8'h00, 8'h00);
		cyc(3);
		chk("fade_cancel", 8'h00, so.bl_code);
		host.wr(8'h00, 8'ha2);
		host.wr(8'h00, 8'h62);
		n = 0;
		while (so.bl_code !== 5'h02 && n < 2000) begin
			cyc(1);
			n++;
		end
		chk("fade_live", 1, n >= 46 * MS && n <= 48 * MS + 40);
		done("fade");
		host.wr(8'h02, 8'h1f);
		@(posedge clk_sys) trig <= 1'b1;
		cyc(6);
		chk("fl_on", 1, so.fl_on);
		chk("fl_step", 8'h08, so.fl_step_50ma);
		chk("fl_mode", 1, so.fl_flash_mode);
		chk("ilim_high", 1, po.ilim_high);
		n = 0;
		while (so.fl_on === 1'b1 && n < 21000) begin
			cyc(1);
			n++;
		end
		chk("timeout", 1, n >= 990 * MS && n <= 1001 * MS);
		chk("bl_kept", {4'h0, en & 4'h7}, so.bl_on);
		rd(8'h03, 8'h05);
		@(posedge clk_sys) trig <= 1'b0;
		cyc(6);
		@(posedge clk_sys) trig <= 1'b1;
		cyc(6);
		chk("fl_rearm", 1, so.fl_on);
		host.wr(8'h03, 8'h00);
		cyc(6);
		chk("fl_sw_off", 0, so.fl_on);
		chk("ilim_low", 0, po.ilim_high);
		host.wr(8'h03, 8'h01);
		host.wr(8'h02, 8'h0e);
		ain.pump_need_up <= 1'b1;
		cyc(8);
		chk("fl_spot", 8'h05, so.fl_step_50ma);
		chk("pump_up", 1, po.mode != ldc_pkg::LDC_PUMP_1X);
		@(posedge clk_sys) ain.pump_need_up <= 1'b0;
		ain.pump_can_down <= 1'b1;
		cyc(1100 * MS);
		chk("spot_on", 1, so.fl_on);
		done("flash");
		@(posedge clk_sys) ain.over_temp_indication <= 1'b1;
		cyc(6);
		chk("ot_bl", 8'h00, so.bl_on);
		chk("ot_fl", 0, so.fl_on);
		@(posedge clk_sys) ain.over_temp_indication <= 1'b0;
		cyc(6);
		rd(8'h01, {4'h0, en & 4'h7});
		chk("ot_back", {4'h0, en & 4'h7}, so.bl_on);
		@(posedge clk_sys) ain.sink_open[0] <= 1'b1;
		cyc(6);
		chk("open_off", 0, so.bl_on[0]);
		@(posedge clk_sys) ain.sink_open[0] <= 1'b0;
		host.wr(8'h01, 8'h00);
		@(posedge clk_sys) trig <= 1'b0;
		cyc(6);
		chk("sleep", 1, sleep_out);
		chk("clk_run", 0, po.clk_run);
		@(posedge clk_sys) ctrl <= 1'b0;
		cyc(6);
		host.wr(8'h02, 8'h03);
		@(posedge clk_sys) ctrl <= 1'b1;
		cyc(5);
		rd(8'h02, 8'h10);
		rd(8'h00, 8'h00);
		cyc(2);
		done("protection");
		end_of_test();
	end
	// Watchdog
	initial begin
		#(60000 * 50);
		err_count++;
		end_of_test();
	end
endmodule // tb
